// ### enhanced_serial_port.sv
/*
  Enhanced serial port: four modes, full duplex outside mode 0, receive buffered,
  multiprocessor filtering in the 9-bit modes.
  Assumes a special function register port on the oscillator clock and
  one-clock overflow pulses from Timer 1 and Timer 2 on the same clock.
*/
`timescale 1ns/10ps
module enhanced_serial_port (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrWriteData,
  output logic [7:0] sfrReadData,
  input wire logic baudDouble,
  input wire logic sixClockMode,
  input wire logic timer1Overflow,
  input wire logic timer2Overflow,
  input wire logic txClockSelect,
  input wire logic rxClockSelect,
  input wire logic rxdIn,
  output logic rxdOut,
  output logic rxdOe,
  output logic txdOut
);
  typedef struct packed {
    logic [7:0] serial_control_status;
    logic [7:0] rxBuf;
    logic [7:0] readData;
    logic [10:0] txShift;
    logic [3:0] txBits;
    logic [6:0] txCnt;
    logic txBusy;
    logic [8:0] rxShift;
    logic [3:0] rxBits;
    logic [6:0] rxCnt;
    logic rxBusy;
    logic rxSync1;
    logic rxSync2;
    logic rxPrev;
  } state_t;

  state_t s;
  state_t next_s;
  logic [1:0] mode;
  logic [6:0] txLen;
  logic [6:0] rxLen;
  logic txTick;
  logic rxTick;
  logic [3:0] txFrame;
  logic [3:0] rxLast;
  logic sbufWrite;
  logic sconWrite;
  logic txDone;
  logic rxDone;
  logic rxKeep;
  logic [8:0] rxNewShift;

  // bit length in base ticks: oscillator clocks or timer overflows
  function automatic logic [6:0] bit_len(input logic [1:0] m,
    input logic useT2, input logic dbl, input logic six);
    if (m == serial_port_pkg::MODE_SHIFT)
      return six ? serial_port_pkg::SHIFT_DIV_6CLK
                 : serial_port_pkg::SHIFT_DIV_12CLK;
    else if (m == serial_port_pkg::MODE_UART9_FIXED)
    begin
      if (six)
        return dbl ? serial_port_pkg::FIXED_DIV_6CLK_DBL
                   : serial_port_pkg::FIXED_DIV_6CLK;
      return dbl ? serial_port_pkg::FIXED_DIV_6CLK
                 : serial_port_pkg::FIXED_DIV_12CLK;
    end
    else if (useT2)
      return serial_port_pkg::TIMER2_DIV;
    else if (six)
      return dbl ? serial_port_pkg::TIMER1_DIV_6CLK_DBL
                 : serial_port_pkg::TIMER1_DIV_6CLK;
    return dbl ? serial_port_pkg::TIMER1_DIV_6CLK
               : serial_port_pkg::TIMER1_DIV_12CLK;
  endfunction

  assign mode = s.serial_control_status[serial_port_pkg::MODE_SELECT_HI:
                       serial_port_pkg::MODE_SELECT_LO];
  assign txLen = bit_len(mode, txClockSelect, baudDouble, sixClockMode);
  assign rxLen = bit_len(mode, rxClockSelect, baudDouble, sixClockMode);
  // mode 0 and 2 count oscillator clocks, modes 1 and 3 count overflows
  assign txTick = (mode == serial_port_pkg::MODE_SHIFT ||
    mode == serial_port_pkg::MODE_UART9_FIXED) ? 1'b1
    : (txClockSelect ? timer2Overflow : timer1Overflow);
  assign rxTick = (mode == serial_port_pkg::MODE_SHIFT ||
    mode == serial_port_pkg::MODE_UART9_FIXED) ? 1'b1
    : (rxClockSelect ? timer2Overflow : timer1Overflow);
  assign txFrame = (mode == serial_port_pkg::MODE_SHIFT) ?
    serial_port_pkg::SHIFT_BITS : (mode == serial_port_pkg::MODE_UART8) ?
    serial_port_pkg::UART8_BITS : serial_port_pkg::UART9_BITS;
  // the stop bit of a 9-bit frame is never sampled
  assign rxLast = (mode == serial_port_pkg::MODE_SHIFT) ?
    serial_port_pkg::SHIFT_LAST_RX : serial_port_pkg::UART_LAST_RX;
  assign sbufWrite = sfrWrite &&
    sfrAddr == serial_port_pkg::SERIAL_BUFFER_ADDR;
  assign sconWrite = sfrWrite &&
    sfrAddr == serial_port_pkg::SERIAL_CONTROL_STATUS_ADDR;
  assign rxNewShift = {s.rxSync2, s.rxShift[8:1]};

  always_comb
  begin
    next_s = s;
    txDone = 1'b0;
    rxDone = 1'b0;
    rxKeep = 1'b0;
    next_s.rxSync1 = rxdIn;
    next_s.rxSync2 = s.rxSync1;
    next_s.rxPrev = s.rxSync2;
    // read data is registered; reads have no side effect
    if (sfrAddr == serial_port_pkg::SERIAL_CONTROL_STATUS_ADDR)
      next_s.readData = s.serial_control_status;
    else if (sfrAddr == serial_port_pkg::SERIAL_BUFFER_ADDR)
      next_s.readData = s.rxBuf;
    else
      next_s.readData = 8'h00;
    if (sconWrite)
      next_s.serial_control_status = sfrWriteData;
    // transmit; a write while busy restarts the frame
    if (sbufWrite)
    begin
      next_s.txBusy = 1'b1;
      next_s.txCnt = 7'h00;
      next_s.txBits = 4'h0;
      if (mode == serial_port_pkg::MODE_SHIFT)
        next_s.txShift = {3'h7, sfrWriteData};
      else
        next_s.txShift = {1'b1, mode[1] ?
          s.serial_control_status[serial_port_pkg::TX_NINTH_BIT] : 1'b1,
          sfrWriteData, 1'b0};
    end
    else if (s.txBusy && txTick)
    begin
      if (s.txCnt == 7'(txLen - 7'h01))
      begin
        next_s.txCnt = 7'h00;
        next_s.txShift = {1'b1, s.txShift[10:1]};
        next_s.txBits = 4'(s.txBits + 4'h1);
        if (s.txBits == 4'(txFrame - 4'h1))
        begin
          next_s.txBusy = 1'b0;
          txDone = 1'b1;
          next_s.serial_control_status[serial_port_pkg::TX_DONE_FLAG] = 1'b1;
        end
      end
      else
        next_s.txCnt = 7'(s.txCnt + 7'h01);
    end
    // receive runs beside transmit, except mode 0 which shares rxd
    if (!s.rxBusy)
    begin
      if (s.serial_control_status[serial_port_pkg::RX_ENABLE] &&
          ((mode == serial_port_pkg::MODE_SHIFT) ?
           (!s.serial_control_status[serial_port_pkg::RX_DONE_FLAG] && !s.txBusy &&
            !sbufWrite) :
           (s.rxPrev && !s.rxSync2)))
      begin
        next_s.rxBusy = 1'b1;
        next_s.rxCnt = 7'h00;
        next_s.rxBits = 4'h0;
      end
    end
    else if (rxTick)
    begin
      if (s.rxCnt == {1'b0, rxLen[6:1]})
      begin
        // a high line at mid start bit is a glitch, not a frame
        if (mode != serial_port_pkg::MODE_SHIFT && s.rxBits == 4'h0 &&
            s.rxSync2)
          next_s.rxBusy = 1'b0;
        else
          next_s.rxShift = rxNewShift;
        if (s.rxBits == rxLast)
        begin
          next_s.rxBusy = 1'b0;
          rxDone = 1'b1;
          rxKeep = mode == serial_port_pkg::MODE_SHIFT ||
            !s.serial_control_status[serial_port_pkg::MULTIPROC_ENABLE] ||
            rxNewShift[8];
          // an unread byte is kept; the new one is dropped
          if (rxKeep && !next_s.serial_control_status[serial_port_pkg::RX_DONE_FLAG])
          begin
            next_s.serial_control_status[serial_port_pkg::RX_DONE_FLAG] = 1'b1;
            if (mode == serial_port_pkg::MODE_SHIFT)
              next_s.rxBuf = rxNewShift[8:1];
            else
            begin
              next_s.rxBuf = rxNewShift[7:0];
              next_s.serial_control_status[serial_port_pkg::RX_NINTH_BIT] =
                rxNewShift[8];
            end
          end
        end
      end
      if (s.rxCnt == 7'(rxLen - 7'h01))
      begin
        next_s.rxCnt = 7'h00;
        next_s.rxBits = 4'(s.rxBits + 4'h1);
      end
      else
        next_s.rxCnt = 7'(s.rxCnt + 7'h01);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s <= '0;
      s.serial_control_status <= serial_port_pkg::SERIAL_CONTROL_STATUS_RESET;
      s.rxBuf <= serial_port_pkg::RX_BUFFER_RESET;
      s.txShift <= 11'h7FF;
      s.rxSync1 <= 1'b1;
      s.rxSync2 <= 1'b1;
      s.rxPrev <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign sfrReadData = s.readData;
  // mode 0: clock low in first half of each bit, data sampled on rise
  assign txdOut = (mode == serial_port_pkg::MODE_SHIFT) ?
    (s.txBusy ? (s.txCnt >= {1'b0, txLen[6:1]}) :
     s.rxBusy ? (s.rxCnt > {1'b0, rxLen[6:1]}) : 1'b1)
    : (s.txBusy ? s.txShift[0] : 1'b1);
  assign rxdOut = s.txShift[0];
  assign rxdOe = mode == serial_port_pkg::MODE_SHIFT && s.txBusy;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence bufWritten;
    sbufWrite;
  endsequence
  sequence frameEnds;
    txDone;
  endsequence

  a_tx_starts: assert property (bufWritten |=> s.txBusy)
    else $error("buffer write did not start transmission");
  a_uart_start_bit: assert property (bufWritten ##0
    (mode != serial_port_pkg::MODE_SHIFT) |=> !txdOut)
    else $error("start bit not driven low");
  a_tx_flag_set: assert property (frameEnds |=>
    s.serial_control_status[serial_port_pkg::TX_DONE_FLAG] && !s.txBusy)
    else $error("transmit done flag not set at frame end");
  a_rx_flag_held: assert property (
    s.serial_control_status[serial_port_pkg::RX_DONE_FLAG] && !sconWrite
    |=> s.serial_control_status[serial_port_pkg::RX_DONE_FLAG])
    else $error("receive done flag dropped by hardware");
  a_no_rx_disabled: assert property (!s.rxBusy &&
    !s.serial_control_status[serial_port_pkg::RX_ENABLE] |=> !s.rxBusy)
    else $error("reception began while disabled");
  a_lost_byte: assert property (rxDone && !sconWrite &&
    s.serial_control_status[serial_port_pkg::RX_DONE_FLAG] |=> s.rxBuf == $past(s.rxBuf))
    else $error("unread byte overwritten");
  a_mp_filter: assert property (rxDone && mode[1] &&
    !rxNewShift[8] && s.serial_control_status[serial_port_pkg::MULTIPROC_ENABLE]
    |=> !$rose(s.serial_control_status[serial_port_pkg::RX_DONE_FLAG]))
    else $error("data byte raised receive flag under filtering");
  a_data_pin_mode0: assert property (rxdOe |->
    mode == serial_port_pkg::MODE_SHIFT &&
    (!$rose(txdOut) || $stable(rxdOut)))
    else $error("rxd driven outside mode 0 or changed at clock rise");
  a_mode2_rate: assert property (s.txBusy && s.txCnt == 7'h00 &&
    mode == serial_port_pkg::MODE_UART9_FIXED && !baudDouble &&
    !sixClockMode && !sbufWrite && !sconWrite
    |-> ##63 (s.txCnt == 7'h3F || !s.txBusy || $past(sfrWrite)))
    else $error("mode 2 bit length is not 64 clocks");
  a_reset_clear: assert property (@(posedge sys_clk) disable iff (1'b0)
    rst |=> s.serial_control_status == serial_port_pkg::SERIAL_CONTROL_STATUS_RESET)
    else $error("control register not cleared by reset");
endmodule

// ### enhanced_serial_port_tb.sv
/*
  Testbench of the enhanced serial port: register reads and writes,
  frames checked against a remote node model.
  Assumes Timer 1 overflows every second clock and Timer 2 every clock,
  so that a wrong clock select shows up as a wrong bit length.
*/
`timescale 1ns/10ps
module enhanced_serial_port_tb;
  logic sys_clk, rst, sfrWrite, baudDouble, tick, tick2, sixClockMode;
  logic txClockSelect, rxClockSelect, rxdOut, rxdOe, txdOut, rxdDrive;
  logic [7:0] sfrAddr, sfrWriteData, sfrReadData, got;
  logic [10:0] frame;
  wire rxdLine = rxdOe ? rxdOut : rxdDrive;
  int errCount, nCompared;

  enhanced_serial_port enhanced_serial_port_inst (
    .sys_clk(sys_clk), .rst(rst), .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite), .sfrWriteData(sfrWriteData),
    .sfrReadData(sfrReadData), .baudDouble(baudDouble),
    .sixClockMode(sixClockMode), .timer1Overflow(tick),
    .timer2Overflow(tick2),
    .txClockSelect(txClockSelect), .rxClockSelect(rxClockSelect),
    .rxdIn(rxdLine), .rxdOut(rxdOut), .rxdOe(rxdOe), .txdOut(txdOut));

  serial_node_model serial_node_model_inst (.sys_clk(sys_clk),
    .txdLine(txdOut), .rxdLine(rxdLine), .rxdDrive(rxdDrive));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) tick <= rst ? 1'b0 : ~tick;
  always @(posedge sys_clk) tick2 <= !rst;

  task automatic summarize();
    $display("compared %0d, mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      errCount++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // waits an edge first so the strobe never changes twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    sfrAddr = a;
    sfrWriteData = d;
    sfrWrite = 1'b1;
    @(posedge sys_clk);
    #1;
    sfrWrite = 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    sfrAddr = a;
    @(posedge sys_clk);
    #1;
    chk({3'h0, sfrReadData}, {3'h0, exp});
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errCount++;
    summarize();
  end

  initial
  begin
    rst = 1'b1;
    sfrAddr = 8'h00;
    sfrWrite = 1'b0;
    sfrWriteData = 8'h00;
    baudDouble = 1'b0;
    sixClockMode = 1'b0;
    txClockSelect = 1'b0;
    rxClockSelect = 1'b0;
    errCount = 0;
    nCompared = 0;
    repeat (20) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    rdChk(8'h98, 8'h00);
    rdChk(8'h99, 8'h00);
    rdChk(8'h55, 8'h00);
    wr(8'h98, 8'h98);
    fork
      serial_node_model_inst.capture(frame, 11, 64);
      wr(8'h99, 8'hA5);
      serial_node_model_inst.send(8'h3C, 1'b0, 1'b1, 1'b1, 64);
    join
    chk(frame, {2'h3, 8'hA5, 1'b0});
    rdChk(8'h98, 8'h9B);
    rdChk(8'h99, 8'h3C);
    serial_node_model_inst.send(8'hC3, 1'b1, 1'b1, 1'b1, 64);
    rdChk(8'h99, 8'h3C);
    baudDouble = 1'b1;
    wr(8'h98, 8'hB0);
    serial_node_model_inst.send(8'h11, 1'b0, 1'b1, 1'b1, 32);
    rdChk(8'h98, 8'hB0);
    serial_node_model_inst.send(8'h22, 1'b1, 1'b1, 1'b1, 32);
    rdChk(8'h98, 8'hB5);
    rdChk(8'h99, 8'h22);
    baudDouble = 1'b0;
    wr(8'h98, 8'h70);
    serial_node_model_inst.send(8'h5A, 1'b0, 1'b0, 1'b0, 64);
    rdChk(8'h98, 8'h70);
    serial_node_model_inst.send(8'h6B, 1'b0, 1'b0, 1'b1, 64);
    rdChk(8'h98, 8'h75);
    rdChk(8'h99, 8'h6B);
    txClockSelect = 1'b1;
    wr(8'h98, 8'hC8);
    fork
      serial_node_model_inst.capture(frame, 11, 16);
      wr(8'h99, 8'h4E);
      serial_node_model_inst.send(8'h77, 1'b1, 1'b1, 1'b1, 64);
    join
    chk(frame, {2'h3, 8'h4E, 1'b0});
    rdChk(8'h98, 8'hCA);
    wr(8'h98, 8'h20);
    fork
      serial_node_model_inst.capture0(got);
      wr(8'h99, 8'h96);
    join
    chk({3'h0, got}, 11'h096);
    repeat (20) @(posedge sys_clk);
    #1;
    rdChk(8'h98, 8'h22);
    fork
      serial_node_model_inst.shift0(8'h61);
      wr(8'h98, 8'h30);
    join
    repeat (20) @(posedge sys_clk);
    #1;
    sfrAddr = 8'h98;
    @(posedge sys_clk);
    #1;
    chk({3'h0, sfrReadData & 8'hFB}, 11'h031);
    rdChk(8'h99, 8'h61);
    sixClockMode = 1'b1;
    rxClockSelect = 1'b1;
    txClockSelect = 1'b0;
    wr(8'h98, 8'hD8);
    fork
      serial_node_model_inst.capture(frame, 11, 32);
      wr(8'h99, 8'h3B);
      serial_node_model_inst.send(8'h5C, 1'b1, 1'b1, 1'b1, 16);
    join
    chk(frame, {2'h3, 8'h3B, 1'b0});
    rdChk(8'h98, 8'hDF);
    rdChk(8'h99, 8'h5C);
    summarize();
  end
endmodule

// ### serial_node_model.sv
/*
  Remote serial node: sends asynchronous frames on rxd, captures frames
  and mode 0 shifts from txd/rxd.
  Assumes sys_clk is the port's oscillator clock and rxd has a pull-up.
*/
`timescale 1ns/10ps
module serial_node_model (
  input wire logic sys_clk,
  input wire logic txdLine,
  input wire logic rxdLine,
  output logic rxdDrive
);
  initial rxdDrive = 1'b1;

  task automatic hold(input logic b, input int len);
    rxdDrive = b;
    repeat (len) @(posedge sys_clk);
    #1;
  endtask

  // stopVal 0 makes a bad stop bit on purpose
  task automatic send(input logic [7:0] d, input logic nine,
    input logic useNine, input logic stopVal, input int len);
    @(posedge sys_clk);
    #1;
    hold(1'b0, len);
    for (int i = 0; i < 8; i++)
      hold(d[i], len);
    if (useNine)
      hold(nine, len);
    hold(stopVal, len);
    rxdDrive = 1'b1;
  endtask

  // samples each bit in its middle, f[0] is the start bit
  task automatic capture(output logic [10:0] f, input int n,
    input int len);
    int w;
    f = '0;
    w = 0;
    while (txdLine !== 1'b0 && w < 4000)
    begin
      @(posedge sys_clk);
      #1;
      w++;
    end
    repeat (len / 2) @(posedge sys_clk);
    #1;
    for (int i = 0; i < n; i++)
    begin
      f[i] = txdLine;
      repeat (len) @(posedge sys_clk);
      #1;
    end
  endtask

  task automatic capture0(output logic [7:0] d);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge txdLine);
      d[i] = rxdLine;
    end
  endtask

  // new bit on each falling shift clock, well before the sample point
  task automatic shift0(input logic [7:0] d);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge txdLine);
      rxdDrive = d[i];
    end
    @(posedge txdLine);
    rxdDrive = 1'b1;
  endtask
endmodule

// ### serial_port_pkg.sv
/*
  Shared constants of the enhanced serial port: special function register
  addresses, control/status field positions, reset value, bit-rate divisors
  and frame lengths.
  Assumes the oscillator clock is the block clock.
*/
package serial_port_pkg;
  // special function register addresses and reset values
  localparam logic [7:0] SERIAL_CONTROL_STATUS_ADDR = 8'h98;
  localparam logic [7:0] SERIAL_BUFFER_ADDR = 8'h99;
  localparam logic [7:0] SERIAL_CONTROL_STATUS_RESET = 8'h00;
  localparam logic [7:0] RX_BUFFER_RESET = 8'h00;
  // field positions inside serial_control_status
  localparam int MODE_SELECT_HI = 7;
  localparam int MODE_SELECT_LO = 6;
  localparam int MULTIPROC_ENABLE = 5;
  localparam int RX_ENABLE = 4;
  localparam int TX_NINTH_BIT = 3;
  localparam int RX_NINTH_BIT = 2;
  localparam int TX_DONE_FLAG = 1;
  localparam int RX_DONE_FLAG = 0;
  // serial modes
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_UART8 = 2'h1;
  localparam logic [1:0] MODE_UART9_FIXED = 2'h2;
  // oscillator clocks per bit, mode 0
  localparam logic [6:0] SHIFT_DIV_12CLK = 7'h0C;
  localparam logic [6:0] SHIFT_DIV_6CLK = 7'h06;
  // oscillator clocks per bit, mode 2
  localparam logic [6:0] FIXED_DIV_12CLK = 7'h40;
  localparam logic [6:0] FIXED_DIV_6CLK = 7'h20;
  localparam logic [6:0] FIXED_DIV_6CLK_DBL = 7'h10;
  // timer overflows per bit, modes 1 and 3
  localparam logic [6:0] TIMER1_DIV_12CLK = 7'h20;
  localparam logic [6:0] TIMER1_DIV_6CLK = 7'h10;
  localparam logic [6:0] TIMER1_DIV_6CLK_DBL = 7'h08;
  localparam logic [6:0] TIMER2_DIV = 7'h10;
  // bits per frame
  localparam logic [3:0] SHIFT_BITS = 4'h8;
  localparam logic [3:0] UART8_BITS = 4'hA;
  localparam logic [3:0] UART9_BITS = 4'hB;
  // index of the last sampled bit on receive
  localparam logic [3:0] SHIFT_LAST_RX = 4'h7;
  localparam logic [3:0] UART_LAST_RX = 4'h9;
endpackage
